// File: shared/cnt_array_pkg.sv
package cnt_array_pkg;

  // Register byte addresses; one aligned 32-bit word each
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_CLK_MODE   = 8'h04;
  localparam logic [7:0] OFS_PWM_CFG    = 8'h08;
  localparam logic [7:0] OFS_COUNTER    = 8'h0C;
  localparam logic [7:0] OFS_MOD_BASE   = 8'h10;
  localparam int unsigned MOD_SHIFT     = 3;
  localparam logic [7:0] OFS_MOD_CMP    = 8'h04;

  // Array control: run and counter overflow in byte 0, match flags byte 1
  localparam int unsigned CTL_RUN       = 0;
  localparam int unsigned CTL_CF        = 1;
  localparam int unsigned CTL_FLAG_LSB  = 8;
  localparam int unsigned CPS_LSB       = 0;
  localparam int unsigned CPS_W         = 3;
  localparam int unsigned CFG_SHARED_CYCLE_LENGTH_LSB = 0;
  localparam int unsigned CFG_RELOAD_SELECT     = 2;
  localparam int unsigned CFG_CYCLE_OVERFLOW_FLAG      = 3;

  // Module mode register bits
  localparam int unsigned MM_WIDE       = 7;
  localparam int unsigned MM_ECOM       = 6;
  localparam int unsigned MM_MAT        = 3;
  localparam int unsigned MM_TOG        = 2;
  localparam int unsigned MM_PWM        = 1;
  localparam int unsigned MM_ECCF       = 0;

  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam int unsigned BASE_BITS     = 8;

  typedef enum logic [1:0] {
    CL_8 = 2'h0, CL_9 = 2'h1, CL_10 = 2'h2, CL_11 = 2'h3
  } cycle_len_t;

  typedef enum logic [2:0] {
    RK_CONTROL, RK_CLK_MODE, RK_PWM_CFG, RK_COUNTER,
    RK_MOD_MODE, RK_MOD_CMP, RK_NONE
  } reg_kind_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] compare;
    logic [15:0] reload;
    logic        pin;
    logic        flag;
    logic        request;
  } chan_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  aw_addr;
    logic        have_aw;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        have_w;
  } axi_t;

endpackage

// File: src/counter_array.sv
`timescale 1ns/1ps
// Overview of operation
// - High-speed output inverts the pin on every full 16-bit match.
// - A match sets the sticky match flag; enabled flag requests service.
// - High-speed output needs toggle, match-flag and comparator enables.
// - High-speed output with comparator off holds the pin level.
// - Low compare byte write clears comparator enable; high byte sets it.
// - Frequency mode: low byte match toggles pin, adds high byte to low.
// - Frequency mode high byte zero means 256 counts between toggles.
// - Frequency mode by comparator, toggle, PWM; flag on 16-bit match.
// - All 8 to 11-bit PWM modules share one cycle length.
// - 8-bit PWM: pin high on low-byte match, low on low-byte wrap.
// - 8-bit PWM: low byte wrap reloads low compare byte from high byte.
// - 8-bit PWM when comparator and PWM enabled and cycle length 00.
// - 8-bit PWM: match flag on match, cycle overflow every 256 counts.
// - Reload select routes compare accesses to the reload register when cycle length is not 00.
// - N-bit PWM: high on N-bit match; overflow drives low and reloads.
// - 9, 10, 11-bit cycle overflows every 512, 1024, 2048 counts.
// - Cycle length codes: 00 8-bit, 01 9-bit, 10 10-bit, 11 11-bit.
// - 9 to 11-bit PWM when enabled and cycle length not 00.
// - Any PWM mode with comparator off holds the pin low.
// - 16-bit PWM: high on 16-bit match, low on counter overflow.
// - 16-bit PWM needs comparator, PWM and wide selects.
module counter_array #(
  parameter int unsigned NUM = 6
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                awvalid,
  output      logic                awready,
  input  wire logic [7:0]          awaddr,
  input  wire logic                wvalid,
  output      logic                wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output      logic                bvalid,
  input  wire logic                bready,
  output      logic [1:0]          bresp,
  input  wire logic                arvalid,
  output      logic                arready,
  input  wire logic [7:0]          araddr,
  output      logic                rvalid,
  input  wire logic                rready,
  output      logic [31:0]         rdata,
  output      logic [1:0]          rresp,
  output      logic [NUM-1:0]      module_output_pin,
  output      logic [NUM-1:0]      match_request
);

  if (NUM < 1 || NUM > 8)
  begin : g_chk
    $error("NUM must lie between 1 and 8");
  end

  typedef struct packed {
    cnt_array_pkg::axi_t              bus;
    logic                             run;
    logic [cnt_array_pkg::CPS_W-1:0]  clk_sel;
    logic [7:0]                       prescale;
    logic [15:0]                      count;
    logic                             cf;
    logic [1:0]                       shared_cycle_length;
    logic                             reload_select;
    logic                             cycle_overflow_flag;
    cnt_array_pkg::chan_t [NUM-1:0]   ch;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic cnt_array_pkg::reg_kind_t decode(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - cnt_array_pkg::OFS_MOD_BASE;
    if (a[1:0] != 2'h0)
      decode = cnt_array_pkg::RK_NONE;
    else if (a == cnt_array_pkg::OFS_CONTROL)
      decode = cnt_array_pkg::RK_CONTROL;
    else if (a == cnt_array_pkg::OFS_CLK_MODE)
      decode = cnt_array_pkg::RK_CLK_MODE;
    else if (a == cnt_array_pkg::OFS_PWM_CFG)
      decode = cnt_array_pkg::RK_PWM_CFG;
    else if (a == cnt_array_pkg::OFS_COUNTER)
      decode = cnt_array_pkg::RK_COUNTER;
    else if (a < cnt_array_pkg::OFS_MOD_BASE
             || 32'(rel >> cnt_array_pkg::MOD_SHIFT) >= NUM)
      decode = cnt_array_pkg::RK_NONE;
    else if (rel[2:0] == cnt_array_pkg::OFS_MOD_CMP[2:0])
      decode = cnt_array_pkg::RK_MOD_CMP;
    else
      decode = cnt_array_pkg::RK_MOD_MODE;
  endfunction

  function automatic logic [2:0] mod_index(input logic [7:0] a);
    logic [7:0] rel;
    rel = (a - cnt_array_pkg::OFS_MOD_BASE) >> cnt_array_pkg::MOD_SHIFT;
    mod_index = rel[2:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Counter timebase and per-module mode decode

  logic                      tick;
  logic [15:0]               cnt_next;
  logic [15:0]               nmask;
  logic                      ovf_n;
  logic                      wide_mode;
  logic [7:0]                presc_limit;
  logic [NUM-1:0]            hso;
  logic [NUM-1:0]            freq;
  logic [NUM-1:0]            pwm_enable;
  logic [NUM-1:0]            pwm16;
  logic [NUM-1:0]            pwm_off;
  logic [NUM-1:0]            m16;
  logic [NUM-1:0]            mlow;
  logic [NUM-1:0]            mn;
  logic [NUM-1:0]            flag_clr;
  logic                      do_write;
  cnt_array_pkg::reg_kind_t  wkind;
  logic [2:0]                widx;
  cnt_array_pkg::reg_kind_t  rkind;
  logic [2:0]                ridx;
  logic [31:0]               rd_value;

  // Counter clock is the system clock divided by two to the select value
  assign presc_limit = 8'((9'h1 << st.clk_sel) - 9'h1);
  assign tick        = st.run && st.prescale == presc_limit;
  assign cnt_next    = st.count + 16'h1;
  assign nmask       = 16'((17'h100 << st.shared_cycle_length) - 17'h1);
  assign ovf_n       = (cnt_next & nmask) == 16'h0;
  assign wide_mode   = st.shared_cycle_length != cnt_array_pkg::CL_8;
  assign do_write    = st.bus.have_aw && st.bus.have_w && !st.bus.bvalid;
  assign wkind       = decode(st.bus.aw_addr);
  assign widx        = mod_index(st.bus.aw_addr);
  assign rkind       = decode(araddr);
  assign ridx        = mod_index(araddr);

  for (genvar i = 0; i < NUM; i++)
  begin : g_mod
    logic [7:0]  md;
    logic [15:0] cp;
    assign md = st.ch[i].mode;
    assign cp = st.ch[i].compare;
    assign hso[i] = md[cnt_array_pkg::MM_ECOM] && md[cnt_array_pkg::MM_TOG]
        && md[cnt_array_pkg::MM_MAT] && !md[cnt_array_pkg::MM_PWM];
    assign freq[i] = md[cnt_array_pkg::MM_ECOM] && md[cnt_array_pkg::MM_TOG]
        && md[cnt_array_pkg::MM_PWM];
    assign pwm16[i] = md[cnt_array_pkg::MM_ECOM] && md[cnt_array_pkg::MM_PWM]
        && md[cnt_array_pkg::MM_WIDE] && !md[cnt_array_pkg::MM_TOG];
    assign pwm_enable[i] = md[cnt_array_pkg::MM_ECOM] && md[cnt_array_pkg::MM_PWM]
        && !md[cnt_array_pkg::MM_WIDE] && !md[cnt_array_pkg::MM_TOG];
    assign pwm_off[i] = !md[cnt_array_pkg::MM_ECOM]
        && md[cnt_array_pkg::MM_PWM] && !md[cnt_array_pkg::MM_TOG];
    assign m16[i]  = cnt_next == cp;
    assign mlow[i] = cnt_next[7:0] == cp[7:0];
    assign mn[i]   = (cnt_next & nmask) == (cp & nmask);
    assign flag_clr[i] = do_write && wkind == cnt_array_pkg::RK_CONTROL
        && st.bus.wstrb[1] && st.bus.wdata[cnt_array_pkg::CTL_FLAG_LSB + i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb
  begin
    rd_value = 32'h0;
    case (rkind)
      cnt_array_pkg::RK_CONTROL:
      begin
        rd_value[cnt_array_pkg::CTL_RUN] = st.run;
        rd_value[cnt_array_pkg::CTL_CF]  = st.cf;
        for (int i = 0; i < NUM; i++)
          rd_value[cnt_array_pkg::CTL_FLAG_LSB + i] = st.ch[i].flag;
      end
      cnt_array_pkg::RK_CLK_MODE:
        rd_value[cnt_array_pkg::CPS_LSB +: cnt_array_pkg::CPS_W] = st.clk_sel;
      cnt_array_pkg::RK_PWM_CFG:
      begin
        rd_value[cnt_array_pkg::CFG_SHARED_CYCLE_LENGTH_LSB +: 2] = st.shared_cycle_length;
        rd_value[cnt_array_pkg::CFG_RELOAD_SELECT] = st.reload_select;
        rd_value[cnt_array_pkg::CFG_CYCLE_OVERFLOW_FLAG]  = st.cycle_overflow_flag;
      end
      cnt_array_pkg::RK_COUNTER:
        rd_value[15:0] = st.count;
      cnt_array_pkg::RK_MOD_MODE:
        rd_value[7:0] = st.ch[ridx].mode;
      cnt_array_pkg::RK_MOD_CMP:
        rd_value[15:0] = (st.reload_select && wide_mode) ? st.ch[ridx].reload
                                                 : st.ch[ridx].compare;
      default:
        rd_value = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;

    // Bus handshakes
    if (awvalid && st.bus.awready)
    begin
      next_st.bus.aw_addr = awaddr;
      next_st.bus.have_aw = 1'b1;
    end
    if (wvalid && st.bus.wready)
    begin
      next_st.bus.wdata  = wdata;
      next_st.bus.wstrb  = wstrb;
      next_st.bus.have_w = 1'b1;
    end
    if (st.bus.bvalid && bready)
      next_st.bus.bvalid = 1'b0;
    if (do_write)
    begin
      next_st.bus.have_aw = 1'b0;
      next_st.bus.have_w  = 1'b0;
      next_st.bus.bvalid  = 1'b1;
      next_st.bus.bresp   = (wkind == cnt_array_pkg::RK_NONE)
                            ? cnt_array_pkg::RESP_SLVERR
                            : cnt_array_pkg::RESP_OKAY;
    end
    if (st.bus.rvalid && rready)
      next_st.bus.rvalid = 1'b0;
    if (arvalid && st.bus.arready)
    begin
      next_st.bus.rvalid = 1'b1;
      next_st.bus.rdata  = rd_value;
      next_st.bus.rresp  = (rkind == cnt_array_pkg::RK_NONE)
                           ? cnt_array_pkg::RESP_SLVERR
                           : cnt_array_pkg::RESP_OKAY;
    end
    next_st.bus.awready = !next_st.bus.have_aw && !next_st.bus.bvalid;
    next_st.bus.wready  = !next_st.bus.have_w && !next_st.bus.bvalid;
    next_st.bus.arready = !next_st.bus.rvalid;

    // Shared timebase
    if (st.run)
      next_st.prescale = tick ? 8'h0 : st.prescale + 8'h1;
    if (tick)
      next_st.count = cnt_next;

    // Pin and compare behaviour by mode
    for (int i = 0; i < NUM; i++)
    begin
      if (tick && hso[i] && m16[i])
        next_st.ch[i].pin = !st.ch[i].pin;
      if (tick && freq[i] && mlow[i])
      begin
        next_st.ch[i].pin = !st.ch[i].pin;
        // Eight-bit add wraps, so a zero step spaces toggles 256 counts
        next_st.ch[i].compare[7:0] = st.ch[i].compare[7:0]
                                   + st.ch[i].compare[15:8];
      end
      if (tick && pwm_enable[i])
      begin
        if (!wide_mode && cnt_next[7:0] == 8'h0)
        begin
          next_st.ch[i].pin = 1'b0;
          next_st.ch[i].compare[7:0] = st.ch[i].compare[15:8];
        end
        else if (wide_mode && ovf_n)
        begin
          next_st.ch[i].pin = 1'b0;
          next_st.ch[i].compare = st.ch[i].reload;
        end
        // Match after overflow lets a zero compare give full duty
        if (wide_mode ? mn[i] : mlow[i])
          next_st.ch[i].pin = 1'b1;
      end
      if (tick && pwm16[i])
      begin
        if (cnt_next == 16'h0)
          next_st.ch[i].pin = 1'b0;
        if (m16[i])
          next_st.ch[i].pin = 1'b1;
      end
      if (pwm_off[i])
        next_st.ch[i].pin = 1'b0;
    end

    // Software writes; flag clears here, hardware sets below so sets win
    if (do_write)
    begin
      case (wkind)
        cnt_array_pkg::RK_CONTROL:
        begin
          if (st.bus.wstrb[0])
          begin
            next_st.run = st.bus.wdata[cnt_array_pkg::CTL_RUN];
            if (st.bus.wdata[cnt_array_pkg::CTL_CF])
              next_st.cf = 1'b0;
          end
          for (int i = 0; i < NUM; i++)
            if (flag_clr[i])
              next_st.ch[i].flag = 1'b0;
        end
        cnt_array_pkg::RK_CLK_MODE:
          if (st.bus.wstrb[0])
          begin
            next_st.clk_sel = st.bus.wdata[cnt_array_pkg::CPS_LSB +:
                                           cnt_array_pkg::CPS_W];
            next_st.prescale = 8'h0;
          end
        cnt_array_pkg::RK_PWM_CFG:
          if (st.bus.wstrb[0])
          begin
            next_st.shared_cycle_length = st.bus.wdata[cnt_array_pkg::CFG_SHARED_CYCLE_LENGTH_LSB +: 2];
            next_st.reload_select = st.bus.wdata[cnt_array_pkg::CFG_RELOAD_SELECT];
            if (st.bus.wdata[cnt_array_pkg::CFG_CYCLE_OVERFLOW_FLAG])
              next_st.cycle_overflow_flag = 1'b0;
          end
        cnt_array_pkg::RK_COUNTER:
        begin
          if (st.bus.wstrb[0])
            next_st.count[7:0] = st.bus.wdata[7:0];
          if (st.bus.wstrb[1])
            next_st.count[15:8] = st.bus.wdata[15:8];
        end
        cnt_array_pkg::RK_MOD_MODE:
          if (st.bus.wstrb[0])
            next_st.ch[widx].mode = st.bus.wdata[7:0];
        cnt_array_pkg::RK_MOD_CMP:
        begin
          // Low then high order matters: the high byte re-arms the comparator
          if (st.bus.wstrb[0])
          begin
            if (st.reload_select && wide_mode)
              next_st.ch[widx].reload[7:0] = st.bus.wdata[7:0];
            else
              next_st.ch[widx].compare[7:0] = st.bus.wdata[7:0];
            next_st.ch[widx].mode[cnt_array_pkg::MM_ECOM] = 1'b0;
          end
          if (st.bus.wstrb[1])
          begin
            if (st.reload_select && wide_mode)
              next_st.ch[widx].reload[15:8] = st.bus.wdata[15:8];
            else
              next_st.ch[widx].compare[15:8] = st.bus.wdata[15:8];
            next_st.ch[widx].mode[cnt_array_pkg::MM_ECOM] = 1'b1;
          end
        end
        default:
          next_st.bus.bresp = cnt_array_pkg::RESP_SLVERR;
      endcase
    end

    // Overflow flags are set after software clears, so a set wins
    if (tick && cnt_next == 16'h0)
      next_st.cf = 1'b1;
    if (tick && ovf_n)
      next_st.cycle_overflow_flag = 1'b1;

    // Sticky match flags and their service requests
    for (int i = 0; i < NUM; i++)
    begin
      if (tick && st.ch[i].mode[cnt_array_pkg::MM_MAT]
          && (((hso[i] || freq[i] || pwm16[i]) && m16[i])
              || (pwm_enable[i] && (wide_mode ? mn[i] : mlow[i]))))
        next_st.ch[i].flag = 1'b1;
      next_st.ch[i].request = next_st.ch[i].flag
          && next_st.ch[i].mode[cnt_array_pkg::MM_ECCF];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign awready = st.bus.awready;
  assign wready  = st.bus.wready;
  assign bvalid  = st.bus.bvalid;
  assign bresp   = st.bus.bresp;
  assign arready = st.bus.arready;
  assign rvalid  = st.bus.rvalid;
  assign rdata   = st.bus.rdata;
  assign rresp   = st.bus.rresp;

  for (genvar i = 0; i < NUM; i++)
  begin : g_out
    assign module_output_pin[i] = st.ch[i].pin;
    assign match_request[i]     = st.ch[i].request;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_count_step: assert property (
    tick && !(do_write && wkind == cnt_array_pkg::RK_COUNTER)
    |=> st.count == $past(cnt_next))
    else $error("counter did not advance on tick");

  a_cycle_overflow_flag_set: assert property (
    tick && ovf_n |=> st.cycle_overflow_flag)
    else $error("cycle overflow flag not set");

  a_cf_set: assert property (
    tick && cnt_next == 16'h0 |=> st.cf)
    else $error("counter overflow flag not set");

  for (genvar i = 0; i < NUM; i++)
  begin : g_chkmod
    a_hso_toggle: assert property (
      tick && hso[i] && m16[i] |=> st.ch[i].pin != $past(st.ch[i].pin))
      else $error("high-speed output did not toggle");

    a_hso_hold: assert property (
      !st.ch[i].mode[cnt_array_pkg::MM_ECOM]
      && !st.ch[i].mode[cnt_array_pkg::MM_PWM]
      && st.ch[i].mode[cnt_array_pkg::MM_TOG]
      |=> $stable(st.ch[i].pin))
      else $error("disabled high-speed output moved");

    a_flag_sticky: assert property (
      st.ch[i].flag && !flag_clr[i] |=> st.ch[i].flag ##1
      (match_request[i] == (st.ch[i].flag
                            && st.ch[i].mode[cnt_array_pkg::MM_ECCF])))
      else $error("match flag or request wrong");

    a_low_write: assert property (
      do_write && wkind == cnt_array_pkg::RK_MOD_CMP && widx == i
      && st.bus.wstrb[1:0] == 2'h1
      |=> !st.ch[i].mode[cnt_array_pkg::MM_ECOM])
      else $error("low byte write left comparator on");

    a_freq_step: assert property (
      tick && freq[i] && mlow[i] && !do_write
      |=> st.ch[i].compare[7:0] == 8'($past(st.ch[i].compare[7:0])
                                    + $past(st.ch[i].compare[15:8])))
      else $error("frequency step not added");

    a_pwm8_reload: assert property (
      tick && pwm_enable[i] && !wide_mode && cnt_next[7:0] == 8'h0 && !do_write
      |=> st.ch[i].compare[7:0] == $past(st.ch[i].compare[15:8]))
      else $error("8-bit reload missing");

    a_pwm_high: assert property (
      tick && ((pwm_enable[i] && (wide_mode ? mn[i] : mlow[i]))
               || (pwm16[i] && m16[i])) |=> st.ch[i].pin)
      else $error("PWM match did not raise pin");

    a_pwm16_low: assert property (
      tick && pwm16[i] && cnt_next == 16'h0 && !m16[i] |=> !st.ch[i].pin)
      else $error("16-bit PWM overflow did not lower pin");

    a_pwm_off: assert property (
      pwm_off[i] |=> !st.ch[i].pin)
      else $error("disabled PWM pin not low");
  end

endmodule

// File: tb/pin_observer.sv
`timescale 1ns/1ps
// Far-side load on one module pin: measures each high pulse in clocks
module pin_observer (
  input wire logic clock,
  input wire logic pin
);
  int run_len = 0;
  int high_len = 0;
  // Sampled mid-cycle so the edge that moves the pin never races the count
  always @(negedge clock)
  begin
    if (pin === 1'b1)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      high_len <= run_len;
      run_len <= 0;
    end
  end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 0, rst = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  logic [5:0] module_output_pin, match_request;
  int bad_count = 0, n_compared = 0;
  localparam logic [7:0] MODE0 = cnt_array_pkg::OFS_MOD_BASE;
  localparam logic [7:0] CMP0 = MODE0 + cnt_array_pkg::OFS_MOD_CMP;
  localparam logic [7:0] MODE1 = MODE0 + 8'h08;
  localparam logic [7:0] CMP1 = MODE0 + 8'h0C;

  counter_array uut (.clock(clock), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .module_output_pin(module_output_pin), .match_request(match_request));
  pin_observer obs (.clock(clock), .pin(module_output_pin[1]));

  initial forever #2 clock = ~clock;

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic aw_ok, w_ok, b_ok;
    b_ok = 0;
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; wstrb <= s;
    bready <= 1;
    // Sample mid-cycle, clear of the edge that moves ready and valid
    while (!b_ok)
    begin
      @(negedge clock);
      aw_ok = awvalid && awready === 1'b1;
      w_ok = wvalid && wready === 1'b1;
      b_ok = bvalid === 1'b1;
      wr_resp = bresp;
      @(posedge clock);
      if (aw_ok) awvalid <= 0;
      if (w_ok) wvalid <= 0;
    end
    bready <= 0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    r_ok = 0;
    arvalid <= 1; araddr <= a; rready <= 1;
    while (!r_ok)
    begin
      @(negedge clock);
      ar_ok = arvalid && arready === 1'b1;
      r_ok = rvalid === 1'b1;
      rd_val = rdata;
      rd_resp = rresp;
      @(posedge clock);
      if (ar_ok) arvalid <= 0;
    end
    rready <= 0;
    @(posedge clock);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Sized from the longest PWM waits with ample margin
  initial
  begin
    #40000;
    bad_count++;
    close_out;
  end

  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    rd(8'hFC);
    chk("unmapped resp", cnt_array_pkg::RESP_SLVERR, rd_resp);
    chk("unmapped data", 32'h0, rd_val);
    wr(8'hFC, 32'h0, 4'hF);
    chk("unmapped wresp", cnt_array_pkg::RESP_SLVERR, wr_resp);
    $display("test map done");
    wr(MODE0, 32'h4D, 4'hF);
    chk("mode0 wresp", cnt_array_pkg::RESP_OKAY, wr_resp);
    wr(CMP0, 32'h10, 4'h1);
    rd(MODE0);
    chk("mode0 after low", 32'h0, rd_val[6]);
    wr(CMP0, 32'h0, 4'h2);
    rd(MODE0);
    chk("mode0 after high", 32'h1, rd_val[6]);
    $display("test ecom done");
    wr(cnt_array_pkg::OFS_CLK_MODE, 32'h0, 4'hF);
    wr(cnt_array_pkg::OFS_CONTROL, 32'h1, 4'hF);
    repeat (20) @(posedge clock);
    chk("hso pin", 32'h1, module_output_pin[0]);
    chk("hso request", 32'h1, match_request[0]);
    wr(cnt_array_pkg::OFS_CONTROL, 32'h100, 4'h3);
    rd(cnt_array_pkg::OFS_CONTROL);
    chk("flag cleared", 32'h0, rd_val[8]);
    wr(CMP0, 32'h10, 4'h1);
    wr(cnt_array_pkg::OFS_COUNTER, 32'h8, 4'h3);
    wr(cnt_array_pkg::OFS_CONTROL, 32'h1, 4'hF);
    repeat (20) @(posedge clock);
    chk("hso held", 32'h1, module_output_pin[0]);
    $display("test hso done");
    wr(cnt_array_pkg::OFS_CONTROL, 32'h0, 4'hF);
    wr(MODE1, 32'h42, 4'hF);
    wr(CMP1, 32'hC080, 4'h3);
    wr(cnt_array_pkg::OFS_COUNTER, 32'h0, 4'h3);
    wr(cnt_array_pkg::OFS_CONTROL, 32'h1, 4'hF);
    repeat (700) @(posedge clock);
    chk("pwm8 high len", 32'd64, obs.high_len);
    rd(cnt_array_pkg::OFS_PWM_CFG);
    chk("pwm8 cycle_overflow_flag", 32'h1, rd_val[3]);
    $display("test pwm8 done");
    wr(cnt_array_pkg::OFS_CONTROL, 32'h0, 4'hF);
    wr(cnt_array_pkg::OFS_COUNTER, 32'h0, 4'h3);
    wr(cnt_array_pkg::OFS_PWM_CFG, 32'h5, 4'hF);
    wr(CMP1, 32'h180, 4'h3);
    rd(CMP1);
    chk("reload readback", 32'h180, rd_val[15:0]);
    wr(MODE1, 32'h42, 4'hF);
    wr(cnt_array_pkg::OFS_CONTROL, 32'h1, 4'hF);
    repeat (1100) @(posedge clock);
    chk("pwm9 high len", 32'd128, obs.high_len);
    wr(MODE1, 32'h02, 4'hF);
    repeat (3) @(posedge clock);
    chk("pwm off pin", 32'h0, module_output_pin[1]);
    $display("test pwm9 done");
    wr(cnt_array_pkg::OFS_CONTROL, 32'h0, 4'hF);
    wr(cnt_array_pkg::OFS_PWM_CFG, 32'h0, 4'hF);
    wr(CMP1, 32'h1010, 4'h3);
    wr(MODE1, 32'h46, 4'hF);
    wr(cnt_array_pkg::OFS_COUNTER, 32'h0, 4'h3);
    wr(cnt_array_pkg::OFS_CONTROL, 32'h1, 4'hF);
    repeat (100) @(posedge clock);
    chk("freq high len", 32'd16, obs.high_len);
    $display("test freq done");
    wr(cnt_array_pkg::OFS_CONTROL, 32'h0, 4'hF);
    wr(CMP1, 32'hFF80, 4'h3);
    wr(MODE1, 32'hCB, 4'hF);
    wr(cnt_array_pkg::OFS_COUNTER, 32'hFF00, 4'h3);
    wr(cnt_array_pkg::OFS_CONTROL, 32'h1, 4'hF);
    // New duty is written once the match request shows the pulse began
    wait (match_request[1] === 1'b1);
    wr(CMP1, 32'hC0, 4'h1);
    wr(CMP1, 32'hFF00, 4'h2);
    repeat (150) @(posedge clock);
    chk("pwm16 high len", 32'd64, obs.high_len);
    rd(cnt_array_pkg::OFS_CONTROL);
    chk("counter overflow", 32'h1, rd_val[1]);
    $display("test pwm16 done");
    close_out;
  end
endmodule
